/* File: verilog/dpig_pkg.sv */
package dpig_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_MSI_LO = 8'h0c;
  localparam logic [7:0] ADDR_MSI_HI = 8'h10;
  localparam logic [7:0] ADDR_MSI_DATA = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  // control field positions
  localparam int CTRL_MSI_EN = 0;
  localparam int CTRL_INTX_DIS = 1;
  localparam int CTRL_W = 2;
  // status and enable field positions
  localparam int SRC_LBW = 0;
  localparam int SRC_LABW = 1;
  localparam int SRC_HP = 2;
  localparam int SRC_W = 3;
  // state field positions
  localparam int STATE_COND = 0;
  localparam int STATE_INTX = 1;
  localparam int STATE_MSI_PEND = 2;
  localparam int STATE_INTX_PEND = 3;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam logic [SRC_W-1:0] SRC_RST = 3'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // message encodings
  localparam logic [1:0] PIN_INTA = 2'h0;
  localparam logic ROUTE_UPSTREAM = 1'b1;
  // request slot widths
  localparam int MSI_W = 97;
  localparam int INTX_W = 3;
endpackage

/* File: verilog/dpig_req_if.sv */
`timescale 1ns/1ps
interface dpig_req_if #(parameter int W = 8);
  logic load;
  logic [W-1:0] data;
  logic busy;
  modport src(output load, output data, input busy);
  modport slot(input load, input data, output busy);
endinterface

/* File: verilog/dpig_req_slot.sv */
`timescale 1ns/1ps
module dpig_req_slot #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // producer side
  dpig_req_if.slot req,
  // consumer side
  output logic valid,
  output logic [W-1:0] data,
  input wire logic ready
);
  logic valid_r;
  logic [W-1:0] data_r;

  assign valid = valid_r;
  assign data = data_r;
  assign req.busy = valid_r;

  // hold one request until taken
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_r <= 1'b0;
    end else if (req.load && !valid_r) begin
      valid_r <= 1'b1;
    end else if (ready) begin
      valid_r <= 1'b0;
    end
  end

  // capture request payload
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_r <= '0;
    end else if (req.load && !valid_r) begin
      data_r <= req.data;
    end
  end
endmodule

/* File: verilog/dpig_top.sv */
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module dpig_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // interrupt event pulses
  input wire logic hp_event,
  input wire logic lbw_set,
  input wire logic labw_set,
  // msi request to switch core
  output logic msi_valid,
  output logic [63:0] msi_addr,
  output logic [31:0] msi_data,
  output logic msi_to_upstream,
  input wire logic msi_ready,
  // legacy message request to switch core
  output logic intx_valid,
  output logic intx_assert,
  output logic [1:0] intx_pin,
  input wire logic intx_ready,
  // level interrupt
  output logic irq
);
  // bus data phase
  logic take;
  logic wr_r;
  logic rd_stage_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_val;

  // software registers
  logic [dpig_pkg::CTRL_W-1:0] ctrl_r;
  logic [dpig_pkg::SRC_W-1:0] status_r;
  logic [dpig_pkg::SRC_W-1:0] enable_r;
  logic [31:0] msi_lo_r;
  logic [31:0] msi_hi_r;
  logic [31:0] msi_dat_r;
  logic [dpig_pkg::SRC_W-1:0] ev;
  logic [dpig_pkg::SRC_W-1:0] clr;

  // interrupt generation
  logic msi_en;
  logic intx_dis;
  logic cond;
  logic cond_d_r;
  logic rise;
  logic fall;
  logic msi_pend_r;
  logic as_pend_r;
  logic de_pend_r;
  logic intx_wire_r;
  logic msi_load;
  logic send_as;
  logic send_de;
  logic intx_load;
  logic [dpig_pkg::INTX_W-1:0] intx_word;
  logic [dpig_pkg::MSI_W-1:0] msi_word;

  dpig_req_if #(.W(dpig_pkg::MSI_W)) msi_req ();
  dpig_req_if #(.W(dpig_pkg::INTX_W)) intx_req ();

  // address phase accept
  assign take = hsel && htrans[1] && hready;
  assign hreadyout = !rd_stage_r;
  assign hrdata = hrdata_r;
  assign hresp = dpig_pkg::HRESP_OKAY;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_r <= 1'b0;
      rd_stage_r <= 1'b0;
    end else begin
      wr_r <= take && hwrite && (hsize == dpig_pkg::HSIZE_WORD);
      rd_stage_r <= take && !hwrite;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r <= 8'h00;
    end else if (take) begin
      addr_r <= {haddr[7:2], 2'b00};
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rd_val = dpig_pkg::WORD_RST;
    unique case (addr_r)
      dpig_pkg::ADDR_CTRL: begin
        rd_val[dpig_pkg::CTRL_W-1:0] = ctrl_r;
      end
      dpig_pkg::ADDR_STATUS: begin
        rd_val[dpig_pkg::SRC_W-1:0] = status_r;
      end
      dpig_pkg::ADDR_ENABLE: begin
        rd_val[dpig_pkg::SRC_W-1:0] = enable_r;
      end
      dpig_pkg::ADDR_MSI_LO: begin
        rd_val = msi_lo_r;
      end
      dpig_pkg::ADDR_MSI_HI: begin
        rd_val = msi_hi_r;
      end
      dpig_pkg::ADDR_MSI_DATA: begin
        rd_val = msi_dat_r;
      end
      dpig_pkg::ADDR_STATE: begin
        rd_val[dpig_pkg::STATE_COND] = cond;
        rd_val[dpig_pkg::STATE_INTX] = intx_wire_r;
        rd_val[dpig_pkg::STATE_MSI_PEND] = msi_pend_r;
        rd_val[dpig_pkg::STATE_INTX_PEND] = as_pend_r || de_pend_r;
      end
      default: begin
        rd_val = dpig_pkg::WORD_RST;
      end
    endcase
  end

  // read data after one wait state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_r <= dpig_pkg::WORD_RST;
    end else if (rd_stage_r) begin
      hrdata_r <= rd_val;
    end
  end

  // control register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= dpig_pkg::CTRL_RST;
    end else if (wr_r && addr_r == dpig_pkg::ADDR_CTRL) begin
      ctrl_r <= hwdata[dpig_pkg::CTRL_W-1:0];
    end
  end

  // enable register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_r <= dpig_pkg::SRC_RST;
    end else if (wr_r && addr_r == dpig_pkg::ADDR_ENABLE) begin
      enable_r <= hwdata[dpig_pkg::SRC_W-1:0];
    end
  end

  // msi address and data registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msi_lo_r <= dpig_pkg::WORD_RST;
      msi_hi_r <= dpig_pkg::WORD_RST;
      msi_dat_r <= dpig_pkg::WORD_RST;
    end else if (wr_r) begin
      if (addr_r == dpig_pkg::ADDR_MSI_LO) begin
        msi_lo_r <= hwdata;
      end
      if (addr_r == dpig_pkg::ADDR_MSI_HI) begin
        msi_hi_r <= hwdata;
      end
      if (addr_r == dpig_pkg::ADDR_MSI_DATA) begin
        msi_dat_r <= hwdata;
      end
    end
  end

  // event sources and write-one clear
  always_comb begin
    ev = dpig_pkg::SRC_RST;
    ev[dpig_pkg::SRC_HP] = hp_event;
    ev[dpig_pkg::SRC_LBW] = lbw_set;
    ev[dpig_pkg::SRC_LABW] = labw_set;
    clr = dpig_pkg::SRC_RST;
    if (wr_r && addr_r == dpig_pkg::ADDR_STATUS) begin
      clr = hwdata[dpig_pkg::SRC_W-1:0];
    end
  end

  // sticky status, set beats clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= dpig_pkg::SRC_RST;
    end else begin
      status_r <= (status_r & ~clr) | ev;
    end
  end

  assign msi_en = ctrl_r[dpig_pkg::CTRL_MSI_EN];
  assign intx_dis = ctrl_r[dpig_pkg::CTRL_INTX_DIS];

  assign cond = |(status_r & enable_r);
  assign irq = cond;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cond_d_r <= 1'b0;
    end else begin
      cond_d_r <= cond;
    end
  end

  assign rise = cond && !cond_d_r;
  assign fall = !cond && cond_d_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msi_pend_r <= 1'b0;
    end else if (rise && msi_en) begin
      msi_pend_r <= 1'b1;
    end else if (msi_load) begin
      msi_pend_r <= 1'b0;
    end
  end

  assign msi_load = msi_pend_r && !msi_req.busy;

  assign msi_word = {dpig_pkg::ROUTE_UPSTREAM, msi_hi_r, msi_lo_r, msi_dat_r};
  assign msi_req.load = msi_load;
  assign msi_req.data = msi_word;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      as_pend_r <= 1'b0;
    end else if (rise && !msi_en && !intx_dis) begin
      as_pend_r <= 1'b1;
    end else if (intx_load && send_as) begin
      as_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      de_pend_r <= 1'b0;
    end else if (fall && !msi_en && !intx_dis) begin
      de_pend_r <= 1'b1;
    end else if (intx_load && send_de) begin
      de_pend_r <= 1'b0;
    end
  end

  // order follows the wire state
  assign send_as = as_pend_r && (!intx_wire_r || !de_pend_r);
  assign send_de = de_pend_r && !send_as;
  assign intx_load = (send_as || send_de) && !intx_req.busy;

  // last message sent
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intx_wire_r <= 1'b0;
    end else if (intx_load) begin
      intx_wire_r <= send_as;
    end
  end

  assign intx_word = {send_as, dpig_pkg::PIN_INTA};
  assign intx_req.load = intx_load;
  assign intx_req.data = intx_word;

  // msi request slot
  dpig_req_slot #(.W(dpig_pkg::MSI_W)) u_msi_slot (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(msi_req),
    .valid(msi_valid),
    .data({msi_to_upstream, msi_addr, msi_data}),
    .ready(msi_ready)
  );

  // legacy message slot
  dpig_req_slot #(.W(dpig_pkg::INTX_W)) u_intx_slot (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(intx_req),
    .valid(intx_valid),
    .data({intx_assert, intx_pin}),
    .ready(intx_ready)
  );
endmodule

/* File: bench/dpig_top_properties.sv */
`timescale 1ns/1ps
module dpig_top_properties (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire logic hreadyout,
  // requests
  input wire logic msi_valid,
  input wire logic [63:0] msi_addr,
  input wire logic msi_to_upstream,
  input wire logic msi_ready,
  input wire logic intx_valid,
  input wire logic intx_assert,
  input wire logic [1:0] intx_pin,
  input wire logic intx_ready
);
  logic wire_r;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // wire state after last taken message
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) wire_r <= 1'b0;
    else if (intx_valid && intx_ready) wire_r <= intx_assert;
  end
  chk_msi_held: assert property (
    msi_valid && !msi_ready |=> msi_valid && $stable(msi_addr))
    else $error("msi request dropped");
  chk_msi_upstream: assert property (
    msi_valid |-> msi_to_upstream) else $error("msi not upstream");
  chk_inta_only: assert property (
    intx_valid |-> intx_pin == dpig_pkg::PIN_INTA)
    else $error("pin not inta");
  chk_intx_toggle: assert property (
    intx_valid |-> intx_assert != wire_r) else $error("no wire change");
  chk_msi_once: assert property (
    msi_valid && msi_ready |=> !msi_valid) else $error("msi repeated");
  chk_intx_once: assert property (
    intx_valid && intx_ready |=> !intx_valid) else $error("intx repeated");
  chk_intx_held: assert property (
    intx_valid && !intx_ready |=> intx_valid && $stable(intx_assert))
    else $error("intx request dropped");
  chk_wait_short: assert property (
    !hreadyout |=> hreadyout) else $error("wait too long");
endmodule

/* File: bench/dpig_core_model.sv */
`timescale 1ns/1ps
module dpig_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pacing
  input wire logic slow,
  // msi path
  input wire logic msi_valid,
  input wire logic [63:0] msi_addr,
  input wire logic msi_to_upstream,
  output logic msi_ready,
  // legacy path
  input wire logic intx_valid,
  input wire logic intx_assert,
  input wire logic [1:0] intx_pin,
  output logic intx_ready,
  // tallies
  output int n_msi,
  output int n_as,
  output int n_de,
  output logic [63:0] last_addr
);
  logic ph;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph <= 1'b0;
      msi_ready <= 1'b0;
      intx_ready <= 1'b0;
    end else begin
      ph <= ~ph;
      msi_ready <= !slow || ph;
      intx_ready <= !slow || !ph;
    end
  end
  always_ff @(posedge clk) begin
    if (msi_valid && msi_ready && msi_to_upstream) begin
      n_msi <= n_msi + 1;
      last_addr <= msi_addr;
    end
  end
  always_ff @(posedge clk) begin
    if (intx_valid && intx_ready && intx_pin == dpig_pkg::PIN_INTA) begin
      if (intx_assert) n_as <= n_as + 1;
      else n_de <= n_de + 1;
    end
  end
endmodule

/* File: bench/dpig_top_bench.sv */
`timescale 1ns/1ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module dpig_top_bench;
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, irq, slow;
  logic [31:0] haddr, hwdata, hrdata, rd, msi_data;
  logic [1:0] htrans, intx_pin;
  logic [2:0] hsize, ev_r;
  logic msi_valid, msi_to_upstream, msi_ready, intx_valid, intx_assert;
  logic intx_ready;
  logic [63:0] msi_addr, last_addr;
  int n_msi, n_as, n_de, fails, n_tests;
  assign hready = hreadyout;
  dpig_top dpig_top_inst (.clk, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .hp_event(ev_r[2]), .lbw_set(ev_r[0]), .labw_set(ev_r[1]),
    .msi_valid, .msi_addr, .msi_data, .msi_to_upstream, .msi_ready,
    .intx_valid, .intx_assert, .intx_pin, .intx_ready, .irq);
  dpig_core_model dpig_core_model_inst (.clk, .sys_rst, .slow,
    .msi_valid, .msi_addr, .msi_to_upstream, .msi_ready, .intx_valid,
    .intx_assert, .intx_pin, .intx_ready, .n_msi, .n_as, .n_de,
    .last_addr);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    logic r;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = hreadyout;
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge clk);
    end
  endtask
  task automatic ev(input int i);
    @(posedge clk);
    ev_r[i] <= 1'b1;
    @(posedge clk);
    ev_r <= 3'h0;
  endtask
  task automatic w;
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic test_done;
    $display("compares %0d errors %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_regs;
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      `CK(rd, 32'h0)
    end
    `CK(hresp, dpig_pkg::HRESP_OKAY)
  endtask
  task automatic t_intx;
    bus(1'b1, dpig_pkg::ADDR_ENABLE, 32'h7);
    ev(2);
    w;
    `CK(irq, 1'b1)
    `CK(n_as, 32'h1)
    // condition and inta wire both up
    bus(1'b0, dpig_pkg::ADDR_STATE, 32'h0);
    `CK(rd, 32'h3)
    bus(1'b1, dpig_pkg::ADDR_STATUS, 32'h4);
    w;
    `CK(irq, 1'b0)
    `CK(n_de, 32'h1)
    bus(1'b0, dpig_pkg::ADDR_STATUS, 32'h0);
    `CK(rd, 32'h0)
  endtask
  task automatic t_mask;
    slow <= 1'b1;
    bus(1'b1, dpig_pkg::ADDR_ENABLE, 32'h6);
    ev(0);
    w;
    `CK(irq, 1'b0)
    bus(1'b1, dpig_pkg::ADDR_ENABLE, 32'h7);
    w;
    `CK(n_as, 32'h2)
    bus(1'b1, dpig_pkg::ADDR_ENABLE, 32'h0);
    w;
    `CK(n_de, 32'h2)
    bus(1'b1, dpig_pkg::ADDR_STATUS, 32'h7);
    bus(1'b1, dpig_pkg::ADDR_ENABLE, 32'h7);
  endtask
  task automatic t_dis;
    bus(1'b1, dpig_pkg::ADDR_CTRL, 32'h2);
    ev(1);
    w;
    `CK(irq, 1'b1)
    `CK(n_as, 32'h2)
    bus(1'b1, dpig_pkg::ADDR_STATUS, 32'h2);
    w;
    `CK(n_de, 32'h2)
  endtask
  task automatic t_msi;
    bus(1'b1, dpig_pkg::ADDR_MSI_LO, 32'h1000);
    bus(1'b1, dpig_pkg::ADDR_MSI_HI, 32'h1);
    bus(1'b1, dpig_pkg::ADDR_MSI_DATA, 32'h0000_00a5);
    bus(1'b0, dpig_pkg::ADDR_MSI_HI, 32'h0);
    `CK(rd, 32'h1)
    for (int c = 1; c < 4; c += 2) begin
      bus(1'b1, dpig_pkg::ADDR_CTRL, c[31:0]);
      ev(2);
      w;
      `CK(n_msi, (c + 1) / 2)
      `CK(last_addr, 64'h1_0000_1000)
      `CK(msi_data, 32'h0000_00a5)
      bus(1'b1, dpig_pkg::ADDR_STATUS, 32'h4);
      w;
      `CK(n_de, 32'h2)
      `CK(n_as, 32'h2)
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ev_r = 3'h0;
    slow = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_intx;
    t_mask;
    t_dis;
    t_msi;
    test_done;
  end
  initial begin
    #100000;
    fails++;
    test_done;
  end
endmodule
bind dpig_top dpig_top_properties dpig_top_properties_inst (.clk,
  .sys_rst, .hreadyout, .msi_valid, .msi_addr, .msi_to_upstream,
  .msi_ready, .intx_valid, .intx_assert, .intx_pin, .intx_ready);
